/* inc/biop_pkg.sv */
package biop_pkg;

  // ------------------------------------------------------------
  // Port geometry and register map
  // ------------------------------------------------------------
  localparam int unsigned   PIN_COUNT       = 8;
  localparam int unsigned   ADDR_W          = 4;
  localparam int unsigned   DATA_W          = 8;

  localparam logic [3:0]    OFS_PORT_DATA   = 4'h0;
  localparam logic [3:0]    OFS_PIN_DIR     = 4'h1;
  localparam logic [3:0]    OFS_PAD_OPTION  = 4'h2;
  localparam logic [3:0]    OFS_IRQ_SENSE   = 4'h3;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0]    RST_PORT_DATA   = 8'h00;
  localparam logic [7:0]    RST_PIN_DIR     = 8'h00;
  localparam logic [7:0]    RST_PAD_OPTION  = 8'h00;
  localparam logic [1:0]    RST_IRQ_SENSE   = 2'h0;

  // ------------------------------------------------------------
  // Sensitivity field of the sense select register, bits 1:0
  // ------------------------------------------------------------
  localparam int unsigned   SENSE_LSB       = 0;
  localparam int unsigned   SENSE_W         = 2;

  typedef enum logic [1:0] {
    BIOP_SENSE_FALL_LOW = 2'h0,
    BIOP_SENSE_RISE     = 2'h1,
    BIOP_SENSE_FALL     = 2'h2,
    BIOP_SENSE_BOTH     = 2'h3
  } biop_sense_t;

endpackage

/* src/biop_port.sv */
// What this block does
// RULE_01 - Eight pins, bit x controls pin x
// RULE_02 - Input direction: data read returns pin level
// RULE_03 - Data write in input mode: latch only
// RULE_04 - Output direction: drive latch, read latch
// RULE_05 - Option selects push-pull or open-drain driver
// RULE_06 - Direction/option pair encodes four pin modes
// RULE_07 - Interrupt input raises request on matching event
// RULE_08 - Programmable sensitivity, each pin requests independently
// RULE_09 - Detect per pin first, then OR
// RULE_10 - Hidden request latch cleared by vector fetch
// RULE_11 - Rewriting sensitivity clears pending request latch
// RULE_12 - Enabled peripheral overrides standard pin settings
// RULE_13 - Peripheral output forces output, its driver type
// RULE_14 - Software sets input mode for peripheral inputs
// RULE_15 - Input config, peripheral output: read peripheral value
// RULE_16 - Output config, peripheral input: feed latch value
// RULE_17 - Deliver only for interrupt mode and unmasked CPU
// RULE_18 - Pins hold state; interrupt wakes from wait/halt
// RULE_19 - Software sets analog pins to floating input
// RULE_20 - Software avoids peripheral on interrupt inputs
// RULE_21 - Software writes data before switching to output
// RULE_22 - High side only push-pull; pull-up only pull-up input
//
// Design decisions made here: the placing of the registers and strobed register access.
module biop_port
  import biop_pkg::*;
#(
  parameter int unsigned       PINS        = PIN_COUNT,
  parameter logic [PINS-1:0]   IRQ_CAPABLE = 8'h0f,
  parameter logic [PINS-1:0]   PULLUP_CAP  = 8'hff
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata,
  input  wire logic [PINS-1:0]   pin_in,
  output logic [PINS-1:0]        pin_out,
  output logic [PINS-1:0]        pin_oe,
  output logic [PINS-1:0]        pullup_en,
  output logic [PINS-1:0]        highside_en,
  input  wire logic [PINS-1:0]   alt_en,
  input  wire logic [PINS-1:0]   alt_out_en,
  input  wire logic [PINS-1:0]   alt_out,
  input  wire logic [PINS-1:0]   alt_open_drain,
  output logic [PINS-1:0]        alt_in,
  input  wire logic              cpu_irq_mask,
  input  wire logic              vector_fetch,
  output logic                   irq_req,
  output logic                   wake_req
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [PINS-1:0]    port_data;
  logic [PINS-1:0]    pin_direction;
  logic [PINS-1:0]    pad_option;
  biop_sense_t        irq_sense_select_reg;
  logic [PINS-1:0]    pin_prev;
  logic               irq_latch;

  logic [PINS-1:0]    alt_drive;
  logic [PINS-1:0]    irq_mode;
  wire  [PINS-1:0]    pin_event;
  logic               any_event;
  logic               wr_data;
  logic               wr_dir;
  logic               wr_opt;
  logic               sense_wr;
  wire  [PINS-1:0]    next_pin_out;
  wire  [PINS-1:0]    next_pin_oe;
  wire  [PINS-1:0]    next_pullup;
  wire  [PINS-1:0]    next_highside;
  wire  [PINS-1:0]    read_view;
  logic [DATA_W-1:0]  next_rdata;

  assign wr_data  = reg_wr && reg_addr == OFS_PORT_DATA;
  assign wr_dir   = reg_wr && reg_addr == OFS_PIN_DIR;
  assign wr_opt   = reg_wr && reg_addr == OFS_PAD_OPTION;
  assign sense_wr = reg_wr && reg_addr == OFS_IRQ_SENSE;

  // Writes only touch the latch; the pads follow the mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_data <= RST_PORT_DATA;
    end
    else if (wr_data)
    begin
      port_data <= reg_wdata[PINS-1:0]; // RULE_03
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_direction <= RST_PIN_DIR;
    end
    else if (wr_dir)
    begin
      pin_direction <= reg_wdata[PINS-1:0]; // RULE_01
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_option <= RST_PAD_OPTION;
    end
    else if (wr_opt)
    begin
      pad_option <= reg_wdata[PINS-1:0]; // RULE_01
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_sense_select_reg <= biop_sense_t'(RST_IRQ_SENSE);
    end
    else if (sense_wr)
    begin
      irq_sense_select_reg <= biop_sense_t'(reg_wdata[SENSE_LSB +: SENSE_W]); // RULE_08
    end
  end

  // ------------------------------------------------------------
  // Pad control
  // ------------------------------------------------------------
  assign alt_drive = alt_en & alt_out_en; // RULE_12

  // One slice per pin, so no pin ever depends on a neighbour's settings
  for (genvar i = 0; i < PINS; i++)
  begin : g_pin
    logic [1:0] mode;
    logic       drv_out;
    logic       drv_oe;
    logic       drv_pu;
    logic       drv_hs;
    logic       seen;
    logic       hit;

    assign mode = {pin_direction[i], pad_option[i]}; // RULE_06

    always_comb
    begin
      drv_out = 1'b0;
      drv_oe  = 1'b0;
      drv_pu  = 1'b0;
      drv_hs  = 1'b0;
      if (alt_drive[i])
      begin
        // Peripheral picks its own driver type
        drv_out = alt_open_drain[i] ? 1'b0 : alt_out[i];  // RULE_13
        drv_oe  = alt_open_drain[i] ? ~alt_out[i] : 1'b1; // RULE_13
        drv_hs  = ~alt_open_drain[i];                     // RULE_22
      end
      else
      begin
        case (mode)
          2'h0:
          begin
            // Floating input: the only safe mode for analog and two-way pins
            drv_pu = 1'b0;
          end
          2'h1:
          begin
            drv_pu = PULLUP_CAP[i]; // RULE_22
          end
          2'h2:
          begin
            // Open drain releases the pin for a latch one
            drv_oe = ~port_data[i]; // RULE_05
          end
          2'h3:
          begin
            drv_out = port_data[i]; // RULE_04
            drv_oe  = 1'b1;         // RULE_05
            drv_hs  = 1'b1;         // RULE_22
          end
          default:
          begin
            drv_oe = 1'b0;
          end
        endcase
      end
    end

    assign next_pin_out[i]  = drv_out;
    assign next_pin_oe[i]   = drv_oe;
    assign next_pullup[i]   = drv_pu;
    assign next_highside[i] = drv_hs;

    // Data read view
    always_comb
    begin
      seen = pin_in[i]; // RULE_02
      if (alt_drive[i] && !pin_direction[i])
      begin
        seen = alt_out[i]; // RULE_15
      end
      else if (pin_direction[i])
      begin
        seen = port_data[i]; // RULE_04
      end
    end

    assign read_view[i] = seen;

    // Per-pin detection comes before the OR across the vector's pins
    always_comb
    begin
      hit = 1'b0;
      case (irq_sense_select_reg)
        BIOP_SENSE_FALL_LOW:
        begin
          hit = ~pin_in[i]; // RULE_07
        end
        BIOP_SENSE_RISE:
        begin
          hit = pin_in[i] & ~pin_prev[i]; // RULE_07
        end
        BIOP_SENSE_FALL:
        begin
          hit = ~pin_in[i] & pin_prev[i]; // RULE_07
        end
        BIOP_SENSE_BOTH:
        begin
          hit = pin_in[i] ^ pin_prev[i]; // RULE_07
        end
        default:
        begin
          hit = 1'b0;
        end
      endcase
    end

    assign pin_event[i] = hit; // RULE_09
  end

  // Registered pads; levels persist in low-power modes as the clock keeps them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_out <= '0;
    else
      pin_out <= next_pin_out; // RULE_18
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_oe <= '0;
    else
      pin_oe <= next_pin_oe;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pullup_en <= '0;
    else
      pullup_en <= next_pullup;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      highside_en <= '0;
    else
      highside_en <= next_highside;
  end

  // Peripheral input sees the latch when the pin is an output
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alt_in <= '0;
    end
    else
    begin
      alt_in <= (pin_direction & port_data) | (~pin_direction & pin_in); // RULE_16
    end
  end

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  always_comb
  begin
    next_rdata = '0;
    case (reg_addr)
      OFS_PORT_DATA:  next_rdata[PINS-1:0] = read_view;
      OFS_PIN_DIR:    next_rdata[PINS-1:0] = pin_direction;
      OFS_PAD_OPTION: next_rdata[PINS-1:0] = pad_option;
      OFS_IRQ_SENSE:  next_rdata[SENSE_LSB +: SENSE_W] = irq_sense_select_reg;
      default:        next_rdata = '0;
    endcase
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= '0;
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_rdata;
    end
    else
    begin
      reg_rdata <= '0;
    end
  end

  // ------------------------------------------------------------
  // External interrupt
  // ------------------------------------------------------------
  // An enabled peripheral keeps a pin out of detection; software should
  // not combine the two in the first place
  assign irq_mode = ~pin_direction & pad_option & IRQ_CAPABLE & ~alt_en; // RULE_17

  // Starts high so a pin held high through reset gives no false rising edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_prev <= '1;
    else
      pin_prev <= pin_in;
  end

  assign any_event = |(pin_event & irq_mode); // RULE_09

  // A new event beats a fetch or sense rewrite in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_latch <= 1'b0;
    end
    else if (any_event)
    begin
      irq_latch <= 1'b1; // RULE_08
    end
    else if (vector_fetch)
    begin
      irq_latch <= 1'b0; // RULE_10
    end
    else if (sense_wr)
    begin
      irq_latch <= 1'b0; // RULE_11
    end
  end

  // Wake ignores the mask: the core unmasks on entering low-power modes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_req <= 1'b0;
    else
      irq_req <= irq_latch & ~cpu_irq_mask; // RULE_17
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wake_req <= 1'b0;
    else
      wake_req <= irq_latch; // RULE_18
  end

endmodule

/* dv/biop_port_assertions.sv */
module biop_port_checker
  import biop_pkg::*;
#(
  parameter int unsigned PINS = PIN_COUNT
)
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic [PINS-1:0]   pin_in,
  input wire logic [PINS-1:0]   pin_out,
  input wire logic [PINS-1:0]   pin_oe,
  input wire logic [PINS-1:0]   pullup_en,
  input wire logic [PINS-1:0]   highside_en,
  input wire logic [PINS-1:0]   alt_en,
  input wire logic [PINS-1:0]   alt_out_en,
  input wire logic [PINS-1:0]   alt_out,
  input wire logic [PINS-1:0]   alt_open_drain,
  input wire logic              cpu_irq_mask,
  input wire logic              vector_fetch,
  input wire logic              irq_req,
  input wire logic              wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PINS-1:0] pp_own;
  assign pp_own = alt_en & alt_out_en & ~alt_open_drain;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_hs; (highside_en & ~pin_oe) == '0; endproperty
  a_hs: assert property (p_hs) else $error("high side on undriven pin");
  property p_od; (pin_oe & ~highside_en & pin_out) == '0; endproperty
  a_od: assert property (p_od) else $error("open drain drives high");
  property p_pu; (pullup_en & pin_oe) == '0; endproperty
  a_pu: assert property (p_pu) else $error("pull-up on driven pin");
  property p_mask; irq_req |-> !$past(cpu_irq_mask); endproperty
  a_mask: assert property (p_mask) else $error("request while masked");
  property p_wake; irq_req |-> wake_req; endproperty
  a_wake: assert property (p_wake) else $error("request without wake");
  property p_alt;
    pp_own != '0 |=> ((pin_oe & $past(pp_own)) == $past(pp_own))
      && (((pin_out ^ $past(alt_out)) & $past(pp_own)) == '0);
  endproperty
  a_alt: assert property (p_alt) else $error("peripheral drive lost");
  // Pins held high and steady so no fresh event may re-arm the latch
  property p_fetch;
    (vector_fetch && &pin_in && $stable(pin_in)) ##1 &pin_in |=> !wake_req;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch left request");
  property p_sense;
    (reg_wr && reg_addr == OFS_IRQ_SENSE && &pin_in && $stable(pin_in)) ##1 &pin_in
      |=> !wake_req;
  endproperty
  a_sense: assert property (p_sense) else $error("sense write left request");
endmodule

bind biop_port biop_port_checker #(.PINS(PINS)) u_chk (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .highside_en(highside_en),
  .alt_en(alt_en), .alt_out_en(alt_out_en), .alt_out(alt_out),
  .alt_open_drain(alt_open_drain), .cpu_irq_mask(cpu_irq_mask),
  .vector_fetch(vector_fetch), .irq_req(irq_req), .wake_req(wake_req));

/* dv/biop_pin_model.sv */
module biop_pin_model
  import biop_pkg::*;
(
  input wire logic           clk,
  input wire logic [7:0]     pin_out,
  input wire logic [7:0]     pin_oe,
  input wire logic [7:0]     pullup_en,
  input wire logic [7:0]     ext,
  input wire logic [7:0]     ext_en,
  output logic [7:0]         pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] flt = 8'h00;
  // Undriven floating pins wander so a stale level never reads back
  always_ff @(posedge clk) flt <= ~flt;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext) | (~ext_en & (pullup_en | flt))));
endmodule

/* dv/biop_port_tb_top.sv */
module biop_port_tb_top
  import biop_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic cpu_irq_mask = 1'b1, vector_fetch = 1'b0, irq_req, wake_req;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, pin_in, pin_out, pin_oe, pullup_en, highside_en;
  logic [7:0] alt_in, alt_en = 8'h00, alt_out_en = 8'h00, alt_out = 8'h00, alt_od = 8'h00;
  logic [7:0] ext = 8'h5a, ext_en = 8'hff;
  logic [3:0] exp_f = 4'hd, exp_r = 4'hb;
  int error_cnt = 0, checks = 0, cyc = 0;
  biop_port u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .highside_en(highside_en),
    .alt_en(alt_en), .alt_out_en(alt_out_en), .alt_out(alt_out), .alt_open_drain(alt_od),
    .alt_in(alt_in), .cpu_irq_mask(cpu_irq_mask), .vector_fetch(vector_fetch),
    .irq_req(irq_req), .wake_req(wake_req));
  biop_pin_model u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext(ext), .ext_en(ext_en), .pin_in(pin_in));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      conclude();
    end
  end
  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(string nm, logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, e);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic fetch;
    @(posedge clk);
    vector_fetch <= 1'b1;
    @(posedge clk);
    vector_fetch <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdc("data", OFS_PORT_DATA, 8'h5a);
    rdc("dir", OFS_PIN_DIR, RST_PIN_DIR);
    rdc("opt", OFS_PAD_OPTION, RST_PAD_OPTION);
    wr(OFS_PORT_DATA, 8'ha5);
    wr(4'h9, 8'hff);
    rdc("unmapped", 4'h9, 8'h00);
    rdc("data", OFS_PORT_DATA, 8'h5a);
    chk("oe", pin_oe, 8'h00);
    $display("input test done");
    wr(OFS_PIN_DIR, 8'hf0);
    wr(OFS_PAD_OPTION, 8'h3c);
    tick(2);
    chk("oe", pin_oe, 8'h70);
    chk("hs", highside_en, 8'h30);
    chk("pu", pullup_en, 8'h0c);
    chk("out", pin_out, 8'h20);
    rdc("data", OFS_PORT_DATA, 8'haa);
    @(posedge clk);
    ext_en <= 8'hf3;
    rdc("pulled", OFS_PORT_DATA, 8'hae);
    $display("output test done");
    @(posedge clk);
    alt_en <= 8'h13;
    ext_en <= 8'hff;
    alt_out_en <= 8'h03;
    alt_out <= 8'h01;
    alt_od <= 8'h02;
    tick(3);
    chk("oe", pin_oe, 8'h73);
    chk("hs", highside_en, 8'h31);
    chk("out", pin_out, 8'h21);
    chk("alt_in", alt_in, 8'ha9);
    rdc("data", OFS_PORT_DATA, 8'ha9);
    @(posedge clk);
    alt_en <= 8'h00;
    ext <= 8'hff;
    $display("alternate test done");
    wr(OFS_PIN_DIR, 8'h00);
    wr(OFS_PAD_OPTION, 8'h0c);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk);
      cpu_irq_mask <= s[0];
      wr(OFS_IRQ_SENSE, 8'(s));
      rdc("sense", OFS_IRQ_SENSE, 8'(s));
      tick(3);
      chk("wake", wake_req, 8'h00);
      @(posedge clk);
      ext <= 8'hf3;
      tick(3);
      chk("wake", wake_req, exp_f[s]);
      chk("irq", irq_req, exp_f[s] & !s[0]);
      fetch();
      ext <= 8'hff;
      tick(3);
      chk("wake", wake_req, exp_r[s]);
      fetch();
      tick(3);
      chk("wake", wake_req, 8'h00);
    end
    $display("interrupt test done");
    conclude();
  end
endmodule
